// File: design/gts_pkg.sv
// constants, register map and field layout of the pin timing-signal selector
// assumes one 250 MHz clock and byte-wide register addresses
package gts_pkg;

  localparam int          GTS_SEL_W         = 5;
  localparam int          GTS_DATA_W        = 16;
  localparam int          GTS_ADDR_W        = 8;

  // register addresses
  localparam logic [7:0]  GTS_ADDR_INT_CFG  = 8'h02;
  localparam logic [7:0]  GTS_ADDR_TSEL     = 8'h0b;
  localparam logic [7:0]  GTS_ADDR_PIN_CFG  = 8'h4f;

  // field positions
  localparam int          GTS_SEL_FIRST_LSB  = 0;
  localparam int          GTS_SEL_SECOND_LSB = 8;
  localparam int          GTS_POL_FIRST_BIT  = 0;
  localparam int          GTS_MODE_FIRST_BIT = 1;
  localparam int          GTS_EN_FIRST_BIT   = 2;
  localparam int          GTS_POL_SECOND_BIT = 8;
  localparam int          GTS_MODE_SECOND_BIT = 9;
  localparam int          GTS_EN_SECOND_BIT  = 6;

  // reset values
  localparam logic [15:0] GTS_TSEL_RST      = 16'h0000;
  localparam logic [15:0] GTS_INT_CFG_RST   = 16'h0000;
  localparam logic        GTS_EN_SECOND_RST = 1'b0;

  // select codes
  localparam logic [4:0]  GTS_CODE_HALF_RATE = 5'h0f;
  localparam logic [4:0]  GTS_CODE_LOGIC0    = 5'h10;
  localparam logic [4:0]  GTS_CODE_LOGIC1    = 5'h11;
  localparam logic [4:0]  GTS_CODE_OSC       = 5'h13;

endpackage

// File: design/gts_pin_stage.sv
// output stage of one timing pin: source select, polarity, drive mode, enable
// assumes all inputs are already in the clock domain
`timescale 1ns/1ns
module gts_pin_stage
  import gts_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [GTS_SEL_W-1:0] sel,
  input  wire logic                 half_rate_toggle,
  input  wire logic                 osc_level,
  input  wire logic                 polarity_low,
  input  wire logic                 drive_when_asserted,
  input  wire logic                 drive_enable,
  output logic                      pin_out,
  output logic                      pin_oe_n
);

  typedef struct packed {
    logic out_r;
    logic oe_n_r;
  } gts_stage_t;

  gts_stage_t state_r;
  gts_stage_t state_nxt;
  logic       source;

  always_comb begin
    source = 1'b0;
    if (sel == GTS_CODE_HALF_RATE) begin
      source = half_rate_toggle;
    end else if (sel == GTS_CODE_LOGIC0) begin
      source = 1'b0;
    end else if (sel == GTS_CODE_LOGIC1) begin
      source = 1'b1;
    end else if (sel == GTS_CODE_OSC) begin
      source = osc_level;
    end
    state_nxt = state_r;
    state_nxt.out_r  = source ^ polarity_low;
    state_nxt.oe_n_r = !(drive_enable && (!drive_when_asserted || source));
  end

  // released pin after reset so nothing fights the shared line
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{out_r: 1'b0, oe_n_r: 1'b1};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pin_out  = state_r.out_r;
  assign pin_oe_n = state_r.oe_n_r;

endmodule

// File: design/gts_timing_select.sv
// Notes on behaviour
// - two independent five-bit select fields live in the timing-select register.
// - code 0x0F drives a square wave toggling once per sample, half rate.
// - toggle starts low entering normal mode, goes high after first sample.
// - code 0x10 holds the pin at logic low.
// - code 0x11 holds the pin at logic high.
// - code 0x13 forwards the 32 kHz oscillator waveform to the pin.
// - bits 12..8 steer the second pin, bits 4..0 the first.
// - per-pin polarity bit and drive-mode bit (always driven or open-drain).
// - a pin drives only while its output-drive enable bit is one.
//
// top of the pin timing-signal selector with its register write/read port
// assumes sample_done and normal_mode come from the sample timing core on clock;
// the oscillator arrives asynchronously and is synchronised here
`timescale 1ns/1ns
module gts_timing_select
  import gts_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  input  wire logic [GTS_ADDR_W-1:0] reg_addr,
  input  wire logic [GTS_DATA_W-1:0] reg_wdata,
  output logic      [GTS_DATA_W-1:0] reg_rdata,
  input  wire logic                  normal_mode,
  input  wire logic                  sample_done,
  input  wire logic                  osc_32k,
  output logic                       timing_pin_first_out,
  output logic                       timing_pin_first_oe_n,
  output logic                       timing_pin_second_out,
  output logic                       timing_pin_second_oe_n,
  output logic                       half_rate_toggle
);

  typedef struct packed {
    logic [GTS_DATA_W-1:0] tsel_r;
    logic [GTS_DATA_W-1:0] int_cfg_r;
    logic                  en_second_r;
    logic                  osc_meta_r;
    logic                  osc_sync_r;
    logic                  toggle_r;
    logic [GTS_DATA_W-1:0] rdata_r;
  } gts_state_t;

  typedef enum logic [1:0] {
    GTS_REG_NONE,
    GTS_REG_TSEL,
    GTS_REG_INT_CFG,
    GTS_REG_PIN_CFG
  } gts_reg_t;

  gts_state_t state_r;
  gts_state_t state_nxt;
  gts_reg_t   reg_hit;

  function automatic logic [GTS_SEL_W-1:0] field_at(input logic [GTS_DATA_W-1:0] word,
                                                    input int lsb);
    field_at = word[lsb +: GTS_SEL_W];
  endfunction

  // shared by the write and the read path so both always agree on the map
  function automatic gts_reg_t reg_decode(input logic [GTS_ADDR_W-1:0] addr);
    if (addr == GTS_ADDR_TSEL) begin
      reg_decode = GTS_REG_TSEL;
    end else if (addr == GTS_ADDR_INT_CFG) begin
      reg_decode = GTS_REG_INT_CFG;
    end else if (addr == GTS_ADDR_PIN_CFG) begin
      reg_decode = GTS_REG_PIN_CFG;
    end else begin
      reg_decode = GTS_REG_NONE;
    end
  endfunction

  assign reg_hit = reg_decode(reg_addr);

  always_comb begin
    state_nxt = state_r;
    // only the bits this block owns are held; the rest of 0x4f reads zero
    if (reg_wr_en) begin
      if (reg_hit == GTS_REG_TSEL) begin
        state_nxt.tsel_r = reg_wdata;
      end else if (reg_hit == GTS_REG_INT_CFG) begin
        state_nxt.int_cfg_r = reg_wdata;
      end else if (reg_hit == GTS_REG_PIN_CFG) begin
        state_nxt.en_second_r = reg_wdata[GTS_EN_SECOND_BIT];
      end
    end
    if (reg_rd_en) begin
      if (reg_hit == GTS_REG_TSEL) begin
        state_nxt.rdata_r = state_r.tsel_r;
      end else if (reg_hit == GTS_REG_INT_CFG) begin
        state_nxt.rdata_r = state_r.int_cfg_r;
      end else if (reg_hit == GTS_REG_PIN_CFG) begin
        state_nxt.rdata_r = '0;
        state_nxt.rdata_r[GTS_EN_SECOND_BIT] = state_r.en_second_r;
      end else begin
        state_nxt.rdata_r = '0;
      end
    end
    // two-flop synchroniser; only the second stage is read
    state_nxt.osc_meta_r = osc_32k;
    state_nxt.osc_sync_r = state_r.osc_meta_r;
    if (!normal_mode) begin
      state_nxt.toggle_r = 1'b0;
    end else if (sample_done) begin
      state_nxt.toggle_r = !state_r.toggle_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{tsel_r: GTS_TSEL_RST, int_cfg_r: GTS_INT_CFG_RST,
                   en_second_r: GTS_EN_SECOND_RST, osc_meta_r: 1'b0,
                   osc_sync_r: 1'b0, toggle_r: 1'b0, rdata_r: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata        = state_r.rdata_r;
  assign half_rate_toggle = state_r.toggle_r;

  gts_pin_stage u_first (
    .clock               (clock),
    .rst_n               (rst_n),
    .sel                 (field_at(state_r.tsel_r, GTS_SEL_FIRST_LSB)),
    .half_rate_toggle    (state_r.toggle_r),
    .osc_level           (state_r.osc_sync_r),
    .polarity_low        (state_r.int_cfg_r[GTS_POL_FIRST_BIT]),
    .drive_when_asserted (state_r.int_cfg_r[GTS_MODE_FIRST_BIT]),
    .drive_enable        (state_r.int_cfg_r[GTS_EN_FIRST_BIT]),
    .pin_out             (timing_pin_first_out),
    .pin_oe_n            (timing_pin_first_oe_n)
  );

  gts_pin_stage u_second (
    .clock               (clock),
    .rst_n               (rst_n),
    .sel                 (field_at(state_r.tsel_r, GTS_SEL_SECOND_LSB)),
    .half_rate_toggle    (state_r.toggle_r),
    .osc_level           (state_r.osc_sync_r),
    .polarity_low        (state_r.int_cfg_r[GTS_POL_SECOND_BIT]),
    .drive_when_asserted (state_r.int_cfg_r[GTS_MODE_SECOND_BIT]),
    .drive_enable        (state_r.en_second_r),
    .pin_out             (timing_pin_second_out),
    .pin_oe_n            (timing_pin_second_oe_n)
  );

endmodule

// File: verification/gts_pin_load.sv
// far-side load of one timing pin
// assumes a pull-up on the line, so a released pin reads high
`timescale 1ns/1ns
module gts_pin_load (
  input  wire logic out,
  input  wire logic oe_n,
  output logic      level
);
  assign level = oe_n ? 1'b1 : out;
endmodule

// File: verification/gts_sva.sv
// assertions on the timing pin selector, bound to its top
// shadows register writes to know what the first pin must show
`timescale 1ns/1ns
module gts_sva
  import gts_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        reg_wr_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        normal_mode,
  input wire logic        sample_done,
  input wire logic        osc_32k,
  input wire logic        timing_pin_first_out,
  input wire logic        timing_pin_first_oe_n,
  input wire logic        half_rate_toggle
);
  logic [15:0] tsel_r;
  logic [15:0] cfg_r;
  wire  [4:0]  s1 = tsel_r[4:0];
  wire         pol = cfg_r[0];
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) {tsel_r, cfg_r} <= 32'h0000_0000;
    else if (reg_wr_en && reg_addr == GTS_ADDR_TSEL) tsel_r <= reg_wdata;
    else if (reg_wr_en && reg_addr == GTS_ADDR_INT_CFG) cfg_r <= reg_wdata;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_idle; !normal_mode |=> !half_rate_toggle; endproperty
  a_idle: assert property (p_idle) else $error("toggle not low");
  property p_step;
    normal_mode && sample_done |=> half_rate_toggle != $past(half_rate_toggle); endproperty
  a_step: assert property (p_step) else $error("toggle missed");
  property p_half; s1 == GTS_CODE_HALF_RATE |=>
    timing_pin_first_out == ($past(half_rate_toggle) ^ $past(pol)); endproperty
  a_half: assert property (p_half) else $error("half rate pin wrong");
  property p_low; s1 == GTS_CODE_LOGIC0 |=> timing_pin_first_out == $past(pol); endproperty
  a_low: assert property (p_low) else $error("low pin wrong");
  property p_high; s1 == GTS_CODE_LOGIC1 |=> timing_pin_first_out != $past(pol); endproperty
  a_high: assert property (p_high) else $error("high pin wrong");
  property p_osc; s1 == GTS_CODE_OSC |=>
    timing_pin_first_out == ($past(osc_32k, 3) ^ $past(pol)); endproperty
  a_osc: assert property (p_osc) else $error("osc pin wrong");
  property p_off; !cfg_r[2] |=> timing_pin_first_oe_n; endproperty
  a_off: assert property (p_off) else $error("pin driven");
  property p_od; cfg_r[2:1] == 2'b11 && s1 == GTS_CODE_LOGIC0 |=> timing_pin_first_oe_n;
  endproperty
  a_od: assert property (p_od) else $error("open drain driven");
  cover property (s1 == GTS_CODE_HALF_RATE && sample_done);
  cover property (s1 == GTS_CODE_OSC && $rose(osc_32k));
  cover property (cfg_r[2:1] == 2'b11 && s1 == GTS_CODE_LOGIC0);
endmodule
bind gts_timing_select gts_sva gts_sva_inst (
  .clock                 (clock),
  .rst_n                 (rst_n),
  .reg_wr_en             (reg_wr_en),
  .reg_addr              (reg_addr),
  .reg_wdata             (reg_wdata),
  .normal_mode           (normal_mode),
  .sample_done           (sample_done),
  .osc_32k               (osc_32k),
  .timing_pin_first_out  (timing_pin_first_out),
  .timing_pin_first_oe_n (timing_pin_first_oe_n),
  .half_rate_toggle      (half_rate_toggle)
);

// File: verification/tb_gts_timing_select.sv
// self-checking bench for the timing pin selector
// assumes pulled-up pin lines and the bound checker
`timescale 1ns/1ns
module tb_gts_timing_select;
  import gts_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic        normal_mode = 1'b0, sample_done = 1'b0, osc_32k = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic        timing_pin_first_out, timing_pin_first_oe_n, lvl1, half_rate_toggle;
  logic        timing_pin_second_out, timing_pin_second_oe_n, lvl2;
  int          err_total = 0, cmp_count = 0;
  always #2 clock = ~clock;
  gts_timing_select gts_timing_select_inst (
    .clock                  (clock),
    .rst_n                  (rst_n),
    .reg_wr_en              (reg_wr_en),
    .reg_rd_en              (reg_rd_en),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_rdata              (reg_rdata),
    .normal_mode            (normal_mode),
    .sample_done            (sample_done),
    .osc_32k                (osc_32k),
    .timing_pin_first_out   (timing_pin_first_out),
    .timing_pin_first_oe_n  (timing_pin_first_oe_n),
    .timing_pin_second_out  (timing_pin_second_out),
    .timing_pin_second_oe_n (timing_pin_second_oe_n),
    .half_rate_toggle       (half_rate_toggle)
  );
  gts_pin_load pin1_load (.out(timing_pin_first_out), .oe_n(timing_pin_first_oe_n),
    .level(lvl1));
  gts_pin_load pin2_load (.out(timing_pin_second_out), .oe_n(timing_pin_second_oe_n),
    .level(lvl2));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clock);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clock);
    {reg_rd_en, reg_addr} = {1'b1, a};
    @(negedge clock);
    reg_rd_en = 1'b0;
    chk("rdata", e, reg_rdata);
  endtask
  // pins packed as first level, first oe_n, second level, second oe_n
  task automatic step(input logic [7:0] a, input logic [15:0] d, input logic [3:0] e);
    wr(a, d);
    @(negedge clock);
    chk("pins", {12'h000, e},
      {12'h000, lvl1, timing_pin_first_oe_n, lvl2, timing_pin_second_oe_n});
  endtask
  task automatic t_regs;
    wr(GTS_ADDR_TSEL, 16'h1311);
    rd(GTS_ADDR_TSEL, 16'h1311);
    wr(GTS_ADDR_INT_CFG, 16'hffff);
    rd(GTS_ADDR_INT_CFG, 16'hffff);
    wr(GTS_ADDR_PIN_CFG, 16'hffff);
    rd(GTS_ADDR_PIN_CFG, 16'h0040);
    rd(8'h33, 16'h0000);
    $display("register test done");
  endtask
  task automatic t_pins;
    wr(GTS_ADDR_PIN_CFG, 16'h0040);
    step(GTS_ADDR_INT_CFG, 16'h0004, 4'b1000);
    step(GTS_ADDR_TSEL, 16'h1011, 4'b1000);
    step(GTS_ADDR_TSEL, 16'h1110, 4'b0010);
    step(GTS_ADDR_INT_CFG, 16'h0105, 4'b1000);
    step(GTS_ADDR_INT_CFG, 16'h0006, 4'b1110);
    step(GTS_ADDR_PIN_CFG, 16'h0000, 4'b1111);
    $display("pin test done");
  endtask
  task automatic t_tog;
    wr(GTS_ADDR_INT_CFG, 16'h0004);
    wr(GTS_ADDR_TSEL, 16'h000f);
    normal_mode = 1'b1;
    repeat (2) @(negedge clock);
    chk("start", 16'h0000, {14'h0, half_rate_toggle, lvl1});
    for (int i = 1; i < 4; i++) begin
      sample_done = 1'b1;
      @(negedge clock);
      sample_done = 1'b0;
      @(negedge clock);
      chk("half", {14'h0, i[0], i[0]}, {14'h0, half_rate_toggle, lvl1});
    end
    normal_mode = 1'b0;
    repeat (2) @(negedge clock);
    chk("stop", 16'h0000, {14'h0, half_rate_toggle, lvl1});
    normal_mode = 1'b1;
    sample_done = 1'b1;
    @(negedge clock);
    sample_done = 1'b0;
    @(negedge clock);
    chk("restart", 16'h0003, {14'h0, half_rate_toggle, lvl1});
    normal_mode = 1'b0;
    $display("toggle test done");
  endtask
  task automatic t_osc;
    wr(GTS_ADDR_TSEL, 16'h0013);
    for (int i = 0; i < 4; i++) begin
      osc_32k = ~osc_32k;
      repeat (3) @(negedge clock);
      chk("osc", {15'h0, osc_32k}, {15'h0, lvl1});
    end
    $display("oscillator test done");
  endtask
  // reset in mid-run must release both pins and clear the read data
  task automatic t_rst;
    rd(GTS_ADDR_TSEL, 16'h0013);
    rst_n = 1'b0;
    @(negedge clock);
    chk("reset pins", 16'h0005, {11'h000, half_rate_toggle, timing_pin_first_out,
      timing_pin_first_oe_n, timing_pin_second_out, timing_pin_second_oe_n});
    chk("reset rdata", 16'h0000, reg_rdata);
    rst_n = 1'b1;
    rd(GTS_ADDR_TSEL, 16'h0000);
    $display("reset test done");
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    t_regs();
    t_pins();
    t_tog();
    t_osc();
    t_rst();
    test_done();
  end
  // about 74 cycles expected; 1000 cycles, over thirteen times that, is a hang
  initial begin
    #4000;
    err_total++;
    test_done();
  end
endmodule
